// ### inc/dab_defines.vh
`ifndef DAB_DEFINES_VH
`define DAB_DEFINES_VH

// register byte offsets inside the 256-byte window
`define DAB_CTRL_BASE 8'h00
`define DAB_CNT_BASE 8'h10
`define DAB_STAT_ADDR 8'h20

// control register fields
`define DAB_F_XE 0
`define DAB_F_EIE 1
`define DAB_F_ME 2
`define DAB_F_FULL 3
`define DAB_F_BLOCK 4
`define DAB_F_BURST 5
`define DAB_F_LEVEL 6
`define DAB_F_SRC 10:8
`define DAB_F_BSIZE 23:16
`define DAB_CTRL_MASK 32'h00ff077f
`define DAB_CTRL_RST 32'h00000000
`define DAB_CNT_RST 16'h0000

// activation source codes
`define DAB_SRC_TMR0 3'h0
`define DAB_SRC_TMR3 3'h3
`define DAB_SRC_RXF 3'h5
`define DAB_SRC_EXT 3'h6
`define DAB_SRC_AUTO 3'h7

// least time from pin request to transfer start, in bus states
`define DAB_MIN_START_STATES 4
// one bus state is one clock, so the cycle count equals the state count
`define DAB_MIN_START_CYC (`DAB_MIN_START_STATES * 1)

`endif

// ### rtl/dab_dma_arbiter.v
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "dab_defines.vh"

// Function
// - short A: timers, serial; B adds pin
// - full: normal pin/auto, block timers/edge
// - enabled activating interrupt withheld from cpu
// - activation clears flag; others stay pending
// - pin source forces request in, done out
// - each falling edge moves one unit, one block in block mode
// - low level keeps requesting, release per unit
// - latched pin request held until unit moves
// - done pin low on last write
// - auto-request starts when enabled, cycle steals
// - burst holds bus, yields to higher
// - dead state then unbroken read/write pair
// - pin start four states late, resampled after read
// - fixed priority 0a 0b 1a 1b
// - request bus, start highest pending at grant
// - short, external, steal units release bus
// - burst/block release at end or preemption
// - external bus or refresh forces release
// - nmi clears full-mode master enable only
// - full channel needs both enables set
// - clearing enables halts after current unit
// - reset and standby initialise; sleep ignored
// - end interrupt when enable clear, irq on
// - halted channel ignores activating interrupts
module dab_dma_arbiter #(
	parameter CNT_W = 16
)(
	input wire ref_clk,
	input wire rst_n,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire [5:0] periph_irq,
	output reg [5:0] periph_irq_clr,
	output reg [5:0] cpu_irq,
	output reg [3:0] end_irq,
	input wire [1:0] ext_xfer_request_pin_n,
	output reg [1:0] req_pin_input,
	output reg [1:0] xfer_done_pin_n,
	output reg [1:0] xfer_done_pin_oe,
	input wire ext_bus_request_pin_n,
	input wire refresh_req,
	input wire nmi,
	input wire hw_standby,
	input wire sw_standby,
	output reg bus_req,
	input wire bus_grant,
	input wire bus_cycle_done,
	output reg dma_dead,
	output reg dma_read,
	output reg dma_write,
	output reg [1:0] dma_chan
);
	localparam S_IDLE = 5'b00001; // no bus wanted
	localparam S_REQ = 5'b00010; // bus requested, waiting grant
	localparam S_DEAD = 5'b00100; // dead state after gaining bus
	localparam S_RD = 5'b01000; // source read
	localparam S_WR = 5'b10000; // destination write
	localparam integer AGE_MIN = `DAB_MIN_START_CYC - 1; // age at which a pin request may start

	// source allowed for this mode and sub-channel
	function src_ok;
		input full;
		input blk;
		input isb;
		input lvl;
		input [2:0] src;
		begin
			src_ok = !full ? ((src <= `DAB_SRC_RXF) || (isb && src == `DAB_SRC_EXT))
				: blk ? ((src <= `DAB_SRC_TMR3) || (src == `DAB_SRC_EXT && !lvl))
				: ((src == `DAB_SRC_EXT) || (src == `DAB_SRC_AUTO));
		end
	endfunction

	// lowest index wins: {found, index}
	function [2:0] pick;
		input [3:0] v;
		begin
			pick = v[0] ? 3'h4 : v[1] ? 3'h5 : v[2] ? 3'h6 : v[3] ? 3'h7 : 3'h0;
		end
	endfunction

	reg [31:0] ctrl_q [0:3]; // per sub-channel control
	reg [CNT_W-1:0] cnt_q [0:3]; // units or blocks left
	reg [7:0] blk_left_q [0:3]; // units left in current block
	reg [2:0] age_q [0:3]; // cycles since request latched
	reg [3:0] pend_q; // latched requests
	reg [3:0] in_blk_q; // block begun, not finished
	reg [4:0] state_q;
	reg [1:0] cur_q; // channel owning the bus
	reg [5:0] irq_prev_q; // for rising edge of peripheral flags
	reg [2:0] pin_s1_q, pin_s2_q, pin_s3_q; // [2] is bus request pin
	reg [2:0] pin_lvl_q; // filtered pin levels
	reg [1:0] samp_en_q; // request pin sampling allowed
	reg [1:0] pin_last_q; // last sampled request level
	reg wr_pend_q; // write data phase pending
	reg [7:0] addr_q;

	reg [3:0] chan_en, cfg_ok, ext_sel, new_req, req_all, elig, higher;
	reg [3:0] is_blk, is_auto;
	reg [5:0] irq_block;
	reg [1:0] pin_fall, pin_low, pair_ext;
	reg [2:0] pk;
	reg [31:0] rd_val;
	reg hold_bus, fin, blk_end, last_unit;
	wire init = !rst_n || hw_standby || sw_standby;
	wire [5:0] irq_rise = periph_irq & ~irq_prev_q;
	integer c;

	// per-channel enables, request sensing and eligibility
	always @*
	begin
		irq_block = 6'h00;
		pair_ext = 2'b00;
		for (c = 0; c < 2; c = c + 1)
		begin
			pin_fall[c] = samp_en_q[c] && pin_last_q[c] && !pin_lvl_q[c];
			pin_low[c] = samp_en_q[c] && !pin_lvl_q[c];
		end
		for (c = 0; c < 4; c = c + 1)
		begin
			// full mode takes the pair's A register; its B half is dead
			cfg_ok[c] = !(ctrl_q[c & 2][`DAB_F_FULL] && c[0])
				&& src_ok(ctrl_q[c & 2][`DAB_F_FULL], ctrl_q[c][`DAB_F_BLOCK], c[0],
					ctrl_q[c][`DAB_F_LEVEL], ctrl_q[c][`DAB_F_SRC]);
			chan_en[c] = cfg_ok[c] && ctrl_q[c][`DAB_F_XE]
				&& (!ctrl_q[c & 2][`DAB_F_FULL] || ctrl_q[c][`DAB_F_ME]);
			is_blk[c] = ctrl_q[c & 2][`DAB_F_FULL] && ctrl_q[c][`DAB_F_BLOCK];
			is_auto[c] = ctrl_q[c][`DAB_F_SRC] == `DAB_SRC_AUTO;
			ext_sel[c] = cfg_ok[c] && ctrl_q[c][`DAB_F_SRC] == `DAB_SRC_EXT;
			if (ext_sel[c])
				pair_ext[c >> 1] = 1'b1;
			// selected and enabled source never reaches the cpu
			if (cfg_ok[c] && ctrl_q[c][`DAB_F_XE] && ctrl_q[c][`DAB_F_SRC] <= `DAB_SRC_RXF)
				irq_block[ctrl_q[c][`DAB_F_SRC]] = 1'b1;
			if (ctrl_q[c][`DAB_F_SRC] <= `DAB_SRC_RXF)
				new_req[c] = irq_rise[ctrl_q[c][`DAB_F_SRC]];
			else if (ext_sel[c])
				new_req[c] = (ctrl_q[c][`DAB_F_LEVEL] && !is_blk[c]) ? pin_low[c >> 1]
					: pin_fall[c >> 1];
			else
				new_req[c] = 1'b0;
			new_req[c] = new_req[c] && chan_en[c];
			// auto-request stands as long as the channel is enabled
			req_all[c] = chan_en[c] && (pend_q[c] || in_blk_q[c] || is_auto[c]);
			elig[c] = req_all[c] && (!ext_sel[c] || in_blk_q[c] || age_q[c] >= AGE_MIN);
		end
		for (c = 0; c < 4; c = c + 1)
			higher[c] = (c > 0) && (elig & ((4'h1 << c) - 4'h1)) != 4'h0;
		pk = pick(elig);
		blk_end = blk_left_q[cur_q] == 8'h01;
		last_unit = is_blk[cur_q] ? blk_end : cnt_q[cur_q] == 16'h0001;
		fin = cnt_q[cur_q] == 16'h0001 && (!is_blk[cur_q] || blk_end);
		// only full-mode burst auto and unfinished blocks keep the bus
		hold_bus = chan_en[cur_q] && !fin && !higher[cur_q]
			&& pin_lvl_q[2] && !refresh_req
			&& (is_blk[cur_q] ? !blk_end
				: (ctrl_q[cur_q][`DAB_F_FULL] && ctrl_q[cur_q][`DAB_F_BURST]
					&& is_auto[cur_q]));
	end

	// register read multiplexer, decoded in the address phase
	always @*
	begin
		rd_val = 32'h00000000;
		case (haddr[7:0])
			8'h00, 8'h04, 8'h08, 8'h0c:
				rd_val = ctrl_q[haddr[3:2]];
			8'h10, 8'h14, 8'h18, 8'h1c:
				rd_val = {8'h00, blk_left_q[haddr[3:2]], cnt_q[haddr[3:2]]};
			`DAB_STAT_ADDR:
				rd_val = {16'h0000, 2'b00, cur_q, bus_req, state_q[4:2], in_blk_q, pend_q};
			default:
				rd_val = 32'h00000000; // unmapped reads zero
		endcase
	end

	// pin synchronisers: a change counts once stages two and three agree
	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			pin_s1_q <= 3'h7;
			pin_s2_q <= 3'h7;
			pin_s3_q <= 3'h7;
			pin_lvl_q <= 3'h7;
		end
		else
		begin
			pin_s1_q <= {ext_bus_request_pin_n, ext_xfer_request_pin_n};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			for (c = 0; c < 3; c = c + 1)
				if (pin_s2_q[c] == pin_s3_q[c])
					pin_lvl_q[c] <= pin_s3_q[c];
		end
	end

	// ahb-lite slave, zero wait states, always okay
	always @(posedge ref_clk)
	begin
		if (init)
		begin
			wr_pend_q <= 1'b0;
			addr_q <= 8'h00;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (hsel && hready && htrans[1])
			begin
				wr_pend_q <= hwrite;
				addr_q <= haddr[7:0];
				if (!hwrite)
					hrdata <= rd_val;
			end
			else
				wr_pend_q <= 1'b0;
		end
	end

	// channel registers, pending requests and bus sequencing
	always @(posedge ref_clk)
	begin
		if (init)
		begin
			for (c = 0; c < 4; c = c + 1)
			begin
				ctrl_q[c] <= `DAB_CTRL_RST;
				cnt_q[c] <= `DAB_CNT_RST;
				blk_left_q[c] <= 8'h00;
				age_q[c] <= 3'h0;
			end
			pend_q <= 4'h0;
			in_blk_q <= 4'h0;
			state_q <= S_IDLE;
			cur_q <= 2'h0;
			irq_prev_q <= 6'h00;
			samp_en_q <= 2'b11;
			pin_last_q <= 2'b11;
			bus_req <= 1'b0;
			dma_dead <= 1'b0;
			dma_read <= 1'b0;
			dma_write <= 1'b0;
			dma_chan <= 2'h0;
			periph_irq_clr <= 6'h00;
			cpu_irq <= 6'h00;
			end_irq <= 4'h0;
			req_pin_input <= 2'b00;
			xfer_done_pin_n <= 2'b11;
			xfer_done_pin_oe <= 2'b00;
		end
		else
		begin
			irq_prev_q <= periph_irq;
			periph_irq_clr <= 6'h00;
			cpu_irq <= periph_irq & ~irq_block;
			req_pin_input <= pair_ext;
			xfer_done_pin_oe <= pair_ext;
			for (c = 0; c < 2; c = c + 1)
				if (samp_en_q[c])
					pin_last_q[c] <= pin_lvl_q[c];
			// software writes first, hardware updates below override
			if (wr_pend_q)
			begin
				if (addr_q[7:4] == 4'h0 && addr_q[1:0] == 2'b00)
				begin
					ctrl_q[addr_q[3:2]] <= hwdata & `DAB_CTRL_MASK;
					blk_left_q[addr_q[3:2]] <= hwdata[`DAB_F_BSIZE];
				end
				else if (addr_q[7:4] == 4'h1 && addr_q[1:0] == 2'b00)
					cnt_q[addr_q[3:2]] <= hwdata[CNT_W-1:0];
			end
			for (c = 0; c < 4; c = c + 1)
			begin
				// channel B end interrupt absent in full mode
				end_irq[c] <= !ctrl_q[c][`DAB_F_XE] && ctrl_q[c][`DAB_F_EIE]
					&& !(ctrl_q[c & 2][`DAB_F_FULL] && c[0]);
				// new request wins over clear; halted channel keeps nothing
				pend_q[c] <= chan_en[c] && (new_req[c] || (pend_q[c] && !(state_q == S_REQ
					&& bus_grant && pk[2] && pk[1:0] == c[1:0])));
				if (!chan_en[c])
					in_blk_q[c] <= 1'b0;
				if (new_req[c] && !pend_q[c])
					age_q[c] <= 3'h0;
				else if (age_q[c] != 3'h7)
					age_q[c] <= age_q[c] + 3'h1;
				if (nmi && ctrl_q[c][`DAB_F_FULL] && !c[0])
					ctrl_q[c][`DAB_F_ME] <= 1'b0;
			end
			case (state_q)
				S_IDLE:
				begin
					if (elig != 4'h0)
					begin
						state_q <= S_REQ;
						bus_req <= 1'b1;
					end
				end
				S_REQ:
				begin
					if (bus_grant)
					begin
						if (pk[2])
						begin
							cur_q <= pk[1:0];
							dma_chan <= pk[1:0];
							state_q <= S_DEAD;
							dma_dead <= 1'b1;
							if (ctrl_q[pk[1:0]][`DAB_F_SRC] <= `DAB_SRC_RXF)
								periph_irq_clr[ctrl_q[pk[1:0]][`DAB_F_SRC]] <= 1'b1;
							if (ext_sel[pk[1:0]])
								samp_en_q[pk[1]] <= 1'b0;
							if (is_blk[pk[1:0]] && !in_blk_q[pk[1:0]])
								in_blk_q[pk[1:0]] <= 1'b1;
						end
						else
						begin
							state_q <= S_IDLE;
							bus_req <= 1'b0;
						end
					end
				end
				S_DEAD:
				begin
					dma_dead <= 1'b0;
					dma_read <= 1'b1;
					state_q <= S_RD;
				end
				S_RD:
				begin
					// read and write are never split by another master
					if (bus_cycle_done)
					begin
						dma_read <= 1'b0;
						dma_write <= 1'b1;
						state_q <= S_WR;
						if (ext_sel[cur_q])
							samp_en_q[cur_q[1]] <= 1'b1;
						if (last_unit)
							xfer_done_pin_n[cur_q[1]] <= 1'b0;
					end
				end
				S_WR:
				begin
					if (bus_cycle_done)
					begin
						dma_write <= 1'b0;
						xfer_done_pin_n <= 2'b11;
						if (!is_blk[cur_q] || blk_end)
							cnt_q[cur_q] <= cnt_q[cur_q] - 16'h0001;
						if (fin)
							ctrl_q[cur_q][`DAB_F_XE] <= 1'b0;
						if (is_blk[cur_q])
						begin
							if (blk_end)
							begin
								blk_left_q[cur_q] <= ctrl_q[cur_q][`DAB_F_BSIZE];
								in_blk_q[cur_q] <= 1'b0;
							end
							else
								blk_left_q[cur_q] <= blk_left_q[cur_q] - 8'h01;
						end
						if (hold_bus)
						begin
							state_q <= S_RD;
							dma_read <= 1'b1;
						end
						else
						begin
							state_q <= S_IDLE;
							bus_req <= 1'b0;
						end
					end
				end
				default:
				begin
					state_q <= S_IDLE;
					bus_req <= 1'b0;
				end
			endcase
		end
	end
endmodule // dab_dma_arbiter

// ### verif/dab_bus_partner.sv
`timescale 1ns/100ps
// cpu side bus arbiter: grants after a lag, ends each bus cycle after a wait
module dab_bus_partner (
	input wire ref_clk,
	input wire rst_n,
	input wire bus_req,
	input wire dma_read,
	input wire dma_write,
	input wire [1:0] lag,
	output reg bus_grant,
	output reg bus_cycle_done
);
	reg [1:0] wait_q; // states waited so far
	// grant only after the lag, and drop it as soon as the request goes
	always @(posedge ref_clk)
	begin
		if (!rst_n || !bus_req)
		begin
			bus_grant <= 1'b0;
			bus_cycle_done <= 1'b0;
			wait_q <= 2'h0;
		end
		else if (bus_cycle_done || !(dma_read || dma_write || !bus_grant))
		begin
			// done is a one cycle pulse
			bus_cycle_done <= 1'b0;
			wait_q <= 2'h0;
		end
		else if (wait_q >= lag)
		begin
			// slow or prompt, whichever the lag says
			bus_grant <= 1'b1;
			bus_cycle_done <= bus_grant;
			wait_q <= 2'h0;
		end
		else
			wait_q <= wait_q + 2'h1;
	end
endmodule // dab_bus_partner

// ### verif/dab_dma_arbiter_sva.sv
`timescale 1ns/100ps
// bus ownership, dead state order and pin/irq relations
module dab_dma_arbiter_sva (
	input wire ref_clk,
	input wire rst_n,
	input wire sw_standby,
	input wire [5:0] periph_irq_clr,
	input wire [5:0] cpu_irq,
	input wire [1:0] xfer_done_pin_n,
	input wire bus_req,
	input wire bus_grant,
	input wire bus_cycle_done,
	input wire dma_dead,
	input wire dma_read,
	input wire dma_write
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	wire busy; // any dma bus state
	assign busy = dma_dead | dma_read | dma_write;
	// one dead state, then straight into the read
	sequence s_dead_rd;
		dma_dead ##1 (dma_read && !dma_dead);
	endsequence
	// read ends, write follows with the bus still held
	sequence s_rd_wr;
		(dma_read && bus_cycle_done) ##1 (dma_write && bus_req);
	endsequence
	dead_then_read_a: assert property (dma_dead |-> s_dead_rd)
		else $error("dead state not followed by read");
	read_to_write_a: assert property (dma_read && bus_cycle_done |-> s_rd_wr)
		else $error("read not followed by write");
	read_holds_a: assert property (dma_read && !bus_cycle_done |=> dma_read)
		else $error("read dropped early");
	grant_starts_a: assert property (bus_req && bus_grant && !busy
		|-> ##[1:8] (dma_dead || !bus_req))
		else $error("no dead state after grant");
	dead_needs_grant_a: assert property ($rose(dma_dead) |-> $past(bus_grant))
		else $error("dead state without grant");
	owns_bus_a: assert property (busy |-> bus_req)
		else $error("bus state without bus request");
	irq_withheld_a: assert property ((periph_irq_clr & cpu_irq) == 6'h00)
		else $error("activating irq reached cpu");
	done_in_write_a: assert property (xfer_done_pin_n != 2'h3 |-> dma_write)
		else $error("done pin low outside write");
	standby_halts_a: assert property (sw_standby |=> !bus_req && !busy)
		else $error("standby did not halt");
endmodule // dab_dma_arbiter_sva
bind dab_dma_arbiter dab_dma_arbiter_sva u_sva (.ref_clk(ref_clk), .rst_n(rst_n),
	.sw_standby(sw_standby), .periph_irq_clr(periph_irq_clr), .cpu_irq(cpu_irq),
	.xfer_done_pin_n(xfer_done_pin_n), .bus_req(bus_req), .bus_grant(bus_grant),
	.bus_cycle_done(bus_cycle_done), .dma_dead(dma_dead), .dma_read(dma_read),
	.dma_write(dma_write));

// ### verif/dab_dma_arbiter_tb.sv
`timescale 1ns/100ps
module dab_dma_arbiter_tb;
	reg ref_clk = 1'b0;
	reg rst_n = 1'b0;
	reg hsel = 1'b0;
	reg [31:0] haddr = 32'h0;
	reg [1:0] htrans = 2'h0;
	reg hwrite = 1'b0;
	reg [31:0] hwdata = 32'h0;
	reg [5:0] periph_irq = 6'h00;
	reg [1:0] pin_n = 2'h3;
	reg nmi = 1'b0;
	reg sw_standby = 1'b0;
	reg [1:0] lag = 2'h0;
	reg [2:0] hsize = 3'h0;
	reg [5:0] irq_set = 6'h00; // one-cycle flag set from the stimulus
	reg bus_pin_n = 1'b1; // external bus request pin
	reg refresh = 1'b0;
	reg hw_sb = 1'b0;
	integer k;
	reg rd_dp = 1'b0; // read data phase
	integer seed = 1;
	integer bad_count = 0;
	integer n_compared = 0;
	integer n_dead = 0; // dead states seen
	integer n_low = 0; // cycles done pin low
	integer base;
	reg [31:0] v;
	reg [31:0] exp_rd[$];
	reg [1:0] exp_ch[$];
	wire [31:0] hrdata;
	wire [5:0] clr, cpu_irq;
	wire [3:0] end_irq;
	wire [1:0] req_in, done_n, done_oe, chan;
	wire hreadyout, hresp, bus_req, grant, cyc_done, dead, rd, wr;
	dab_dma_arbiter u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .periph_irq(periph_irq),
		.periph_irq_clr(clr), .cpu_irq(cpu_irq), .end_irq(end_irq),
		.ext_xfer_request_pin_n(pin_n), .req_pin_input(req_in), .xfer_done_pin_n(done_n),
		.xfer_done_pin_oe(done_oe), .ext_bus_request_pin_n(bus_pin_n), .refresh_req(refresh),
		.nmi(nmi), .hw_standby(hw_sb), .sw_standby(sw_standby), .bus_req(bus_req),
		.bus_grant(grant), .bus_cycle_done(cyc_done), .dma_dead(dead), .dma_read(rd),
		.dma_write(wr), .dma_chan(chan));
	dab_bus_partner u_far (.ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req),
		.dma_read(rd), .dma_write(wr), .lag(lag), .bus_grant(grant),
		.bus_cycle_done(cyc_done));
	// clock, 8 ns period
	initial
	begin
		forever #4 ref_clk = ~ref_clk;
	end
	task chk(input [31:0] seen, input [31:0] want, input string nm);
	begin
		n_compared = n_compared + 1;
		if (seen !== want)
		begin
			bad_count = bad_count + 1;
			$display("wrong value %s expected %h seen %h", nm, want, seen);
		end
	end
	endtask
	// one single ahb transfer, waits on hready in both phases
	task ahb(input w, input [7:0] a, input [31:0] d);
	begin
		@(posedge ref_clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		@(posedge ref_clk);
		while (hreadyout !== 1'b1) @(posedge ref_clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rd_dp <= !w;
		@(posedge ref_clk);
		while (hreadyout !== 1'b1) @(posedge ref_clk);
		rd_dp <= 1'b0;
	end
	endtask
	task idle;
	begin
		while (bus_req !== 1'b0 || exp_ch.size() > 0) @(posedge ref_clk);
		repeat (4) @(posedge ref_clk);
	end
	endtask
	task complete_run;
	begin
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	// watcher: oldest note against what appears; partner lag and flag clear
	always @(posedge ref_clk)
	begin
		lag <= $random(seed);
		periph_irq <= (periph_irq & ~clr) | irq_set;
		if (rd_dp && hreadyout)
		begin
			chk(hrdata, exp_rd.pop_front(), "hrdata");
			chk(hresp, 0, "hresp");
		end
		if (dead === 1'b1)
			n_dead = n_dead + 1;
		if (done_n !== 2'h3)
			n_low = n_low + 1;
		if (dead === 1'b1 && exp_ch.size() > 0)
			chk({30'h0, chan}, {30'h0, exp_ch.pop_front()}, "dma_chan");
	end
	initial
	begin
		#400000;
		bad_count = bad_count + 1;
		complete_run;
	end
	initial
	begin
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		exp_rd.push_back(32'h0);
		ahb(0, 8'h00, 0);
		exp_rd.push_back(32'h0);
		ahb(0, 8'h40, 0);
		v = $random(seed) & 32'h00ff077e;
		ahb(1, 8'h08, v);
		exp_rd.push_back(v);
		ahb(0, 8'h08, 0);
		chk(end_irq[2], v[1], "end_irq");
		ahb(1, 8'h08, 0);
		// auto cycle steal, full mode channel 0, three units
		base = n_dead;
		repeat (3) exp_ch.push_back(2'h0);
		ahb(1, 8'h10, 3);
		ahb(1, 8'h00, 32'h70f);
		while (end_irq[0] !== 1'b1) @(posedge ref_clk);
		idle;
		chk(n_dead - base, 3, "units");
		// one timer flag shared by 0b and 1b
		ahb(1, 8'h00, 0);
		ahb(1, 8'h14, 1);
		ahb(1, 8'h1c, 1);
		ahb(1, 8'h04, 32'h1);
		ahb(1, 8'h0c, 32'h1);
		exp_ch.push_back(2'h1);
		exp_ch.push_back(2'h3);
		irq_set <= 6'h01;
		@(posedge ref_clk);
		irq_set <= 6'h00;
		repeat (3) @(posedge ref_clk);
		chk(cpu_irq, 0, "cpu_irq");
		idle;
		chk(periph_irq, 0, "flag");
		// falling edges on pair 0 pin, two units
		base = n_dead;
		ahb(1, 8'h14, 2);
		ahb(1, 8'h04, 32'h601);
		repeat (2) @(posedge ref_clk);
		chk(req_in, 1, "req_pin_input");
		chk(done_oe, 1, "done_oe");
		repeat (2)
		begin
			exp_ch.push_back(2'h1);
			pin_n <= 2'h2;
			repeat (8) @(posedge ref_clk);
			pin_n <= 2'h3;
			idle;
		end
		chk(n_dead - base, 2, "units");
		chk(n_low > 0, 1, "done pin");
		// long burst, stopped by nmi, then standby
		ahb(1, 8'h04, 0);
		ahb(1, 8'h10, 40);
		ahb(1, 8'h00, 32'h72d);
		while (dead !== 1'b1) @(posedge ref_clk);
		nmi <= 1'b1;
		@(posedge ref_clk);
		nmi <= 1'b0;
		idle;
		exp_rd.push_back(32'h729);
		ahb(0, 8'h00, 0);
		// master enable set again: the halted burst runs to its end
		ahb(1, 8'h00, 32'h72f);
		while (end_irq[0] !== 1'b1) @(posedge ref_clk);
		idle;
		exp_rd.push_back(32'h72e);
		ahb(0, 8'h00, 0);
		sw_standby <= 1'b1;
		repeat (2) @(posedge ref_clk);
		sw_standby <= 1'b0;
		exp_rd.push_back(32'h0);
		ahb(0, 8'h00, 0);
		// refresh, then the external bus request pin, chop a burst into units
		for (k = 0; k < 2; k = k + 1)
		begin
			base = n_dead;
			refresh <= (k == 0);
			bus_pin_n <= (k == 0);
			repeat (4) exp_ch.push_back(2'h0);
			ahb(1, 8'h10, 4);
			ahb(1, 8'h00, 32'h72d);
			idle;
			chk(n_dead - base, 4, "units");
		end
		refresh <= 1'b0;
		bus_pin_n <= 1'b1;
		hw_sb <= 1'b1;
		repeat (2) @(posedge ref_clk);
		hw_sb <= 1'b0;
		exp_rd.push_back(32'h0);
		ahb(0, 8'h00, 0);
		complete_run;
	end
endmodule // dab_dma_arbiter_tb
